// >>> design/irq_agg_cfg.svh
// register map, field positions and timing constants of the interrupt aggregator
`ifndef IRQ_AGG_CFG_SVH
`define IRQ_AGG_CFG_SVH

// register byte addresses
`define ADR_STATUS 8'h00
`define ADR_USBMASK 8'h04
`define ADR_CTL 8'h08
`define ADR_EPSTAT 8'h0c
`define ADR_EPMASK 8'h10
`define ADR_MISC 8'h14
`define ADR_VECTOR 8'h18
`define ADR_POWER 8'h1c
`define ADR_WAKEMASK 8'h20

// pending vector layout
`define NSRC 27
`define NEP 8
`define NUSB 7
`define NMISC 4
`define SRC_IN 0
`define SRC_OUT 8
`define SRC_USB 16
`define SRC_RST 16
`define SRC_SUS 17
`define SRC_RES 18
`define SRC_SOF 19
`define SRC_MISS 20
`define SRC_SETUP 21
`define SRC_OVR 22
`define SRC_MISC 23
`define SRC_SER 23
`define SRC_DMA0 24
`define SRC_DMA1 25
`define SRC_EXT 26
`define USB_STAT_MASK 27'h07f0000

// control and power register bits
`define CTL_FRGE 0
`define CTL_P33IRQ 1
`define CTL_XEN 2
`define PWR_IDLE 0
`define PWR_SUSP 1
`define P3_IRQ_BIT 3

// timing
`define CLK_FREQ_MHZ 20
`define SUSPEND_TIME_US 5000
`define FRAME_TIME_US 1000
`define GRES_CYCLES 4'h8

`endif

// >>> design/irq_agg_pkg.sv
// shared types of the interrupt aggregator
package irq_agg_pkg;

    // event strobes from the serial interface engine and buffer manager
    typedef struct packed {
        logic [7:0] inAck;
        logic [7:0] inIso;
        logic [7:0] outDone;
        logic [7:0] outIso;
        logic busReset;
        logic busIdleJ;
        logic busActivity;
        logic sofRx;
        logic setupOk;
    } usb_evt_t;

    typedef enum logic [1:0] {LINK_ACTIVE, LINK_SUSPENDED, LINK_CLK_STOPPED} link_state_t;

endpackage

// >>> design/irq_sync.sv
// two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/10ps
module irq_sync #(
    parameter int W = 9
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta;

    // pins idle high, so both stages reset to ones
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            meta <= '1;
            dout <= '1;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule

// >>> design/usb_streaming_irq_aggregator.sv
// interrupt, usb reset and suspend/wake aggregation for the on-chip controller core
`timescale 1ns/10ps
`include "irq_agg_cfg.svh"
module usb_streaming_irq_aggregator #(
    parameter int SUSPEND_CYCLES = `SUSPEND_TIME_US * `CLK_FREQ_MHZ,
    parameter int FRAME_CYCLES = `FRAME_TIME_US * `CLK_FREQ_MHZ
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    input irq_agg_pkg::usb_evt_t usbEvt,
    input wire logic serialIrq,
    input wire logic dma0Done,
    input wire logic dma1Done,
    input wire logic externalIrqN,
    input wire logic [7:0] port3Pin,
    output logic mergedIrqInput,
    output logic secondaryIrqInput,
    output logic cpuClkRun,
    output logic cpuReset,
    output logic resetOutPin,
    output logic usbLogicReset
);
    logic [8:0] syncIn, prevIn;
    logic [`NSRC-1:0] pend, next_pend, setVec, clrVec, gresClr, enVec;
    logic [`NUSB-1:0] usbMask, next_usbMask;
    logic [15:0] epMask, next_epMask;
    logic [2:0] ctl, next_ctl;
    logic [7:0] wakeMask, next_wakeMask, portFall;
    logic idleBit, next_idleBit, wbWr, extFall, wake, gres, suspendHit, missHit, anyEn;
    logic [31:0] rdData, selMask, wdat;
    logic [16:0] idleCnt, next_idleCnt;
    logic [15:0] frameCnt, next_frameCnt;
    logic [3:0] gresCnt, next_gresCnt;
    irq_agg_pkg::link_state_t linkState, next_linkState;

    irq_sync #(.W(9)) u_irq_sync (
        .clk_sys(clk_sys), .rst(rst), .din({port3Pin, externalIrqN}), .dout(syncIn)
    );

    // falling edges seen on the synchronised pins
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            prevIn <= 9'h1ff;
        end else begin
            prevIn <= syncIn;
        end
    end

    assign extFall = prevIn[0] & ~syncIn[0];
    assign portFall = prevIn[8:1] & ~syncIn[8:1] & ~wakeMask;
    assign wake = usbEvt.busActivity | extFall | (|portFall);
    assign gres = usbEvt.busReset & ctl[`CTL_FRGE];
    assign gresClr = gres ? `USB_STAT_MASK : '0;
    assign suspendHit = usbEvt.busIdleJ && (idleCnt == 17'(SUSPEND_CYCLES));
    assign missHit = (linkState == irq_agg_pkg::LINK_ACTIVE) && !usbEvt.sofRx
        && (frameCnt == 16'(FRAME_CYCLES));

    // bus slave write strobe: takes effect on the acknowledging edge
    assign wbWr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
    assign selMask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign wdat = wb_dat_i & selMask;

    // event sources into the pending vector
    always_comb begin
        setVec = '0;
        setVec[`SRC_OUT +: `NEP] = usbEvt.outDone & ~usbEvt.outIso;
        setVec[`SRC_IN +: `NEP] = usbEvt.inAck & ~usbEvt.inIso;
        setVec[`SRC_RST] = usbEvt.busReset & ~ctl[`CTL_FRGE];
        setVec[`SRC_SUS] = suspendHit;
        setVec[`SRC_RES] = usbEvt.busActivity & (linkState != irq_agg_pkg::LINK_ACTIVE);
        setVec[`SRC_SOF] = usbEvt.sofRx;
        setVec[`SRC_MISS] = missHit;
        setVec[`SRC_SETUP] = usbEvt.setupOk;
        setVec[`SRC_OVR] = usbEvt.setupOk & pend[`SRC_SETUP];
        setVec[`SRC_SER] = serialIrq;
        setVec[`SRC_DMA0] = dma0Done;
        setVec[`SRC_DMA1] = dma1Done;
        setVec[`SRC_EXT] = extFall & ctl[`CTL_XEN];
    end

    // vector write clears the numbered source
    always_comb begin
        clrVec = '0;
        if (wbWr && wb_sel_i[0] && (wb_adr_i == `ADR_VECTOR) && (wdat[4:0] < 5'(`NSRC))) begin
            clrVec[wdat[4:0]] = 1'b1;
        end
    end

    // per source: set beats clear, global reset clears the usb status
    genvar gi;
    generate
        for (gi = 0; gi < `NSRC; gi++) begin : g_pend
            assign next_pend[gi] = (setVec[gi] | (pend[gi] & ~clrVec[gi])) & ~gresClr[gi];
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pend <= '0;
        end else begin
            pend <= next_pend;
        end
    end

    // software registers
    always_comb begin
        next_usbMask = usbMask;
        next_epMask = epMask;
        next_ctl = ctl;
        next_wakeMask = wakeMask;
        next_idleBit = idleBit;
        if (wbWr && (wb_adr_i == `ADR_USBMASK)) begin
            next_usbMask = (usbMask & ~selMask[`NUSB-1:0]) | wdat[`NUSB-1:0];
        end else if (wbWr && (wb_adr_i == `ADR_EPMASK)) begin
            next_epMask = (epMask & ~selMask[15:0]) | wdat[15:0];
        end else if (wbWr && (wb_adr_i == `ADR_CTL)) begin
            next_ctl = (ctl & ~selMask[2:0]) | wdat[2:0];
        end else if (wbWr && (wb_adr_i == `ADR_WAKEMASK)) begin
            next_wakeMask = (wakeMask & ~selMask[7:0]) | wdat[7:0];
        end else if (wbWr && (wb_adr_i == `ADR_POWER) && wb_sel_i[0]) begin
            next_idleBit = wdat[`PWR_IDLE];
        end
        // a wake event ends idle
        if (wake && (linkState != irq_agg_pkg::LINK_ACTIVE)) begin
            next_idleBit = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            usbMask <= '0;
            epMask <= '0;
            ctl <= '0;
            wakeMask <= '0;
            idleBit <= 1'b0;
        end else begin
            usbMask <= next_usbMask;
            epMask <= next_epMask;
            ctl <= next_ctl;
            wakeMask <= next_wakeMask;
            idleBit <= next_idleBit;
        end
    end

    // read multiplexer
    always_comb begin
        rdData = '0;
        if (wb_adr_i == `ADR_STATUS) begin
            rdData[`NUSB-1:0] = pend[`SRC_USB +: `NUSB];
        end else if (wb_adr_i == `ADR_USBMASK) begin
            rdData[`NUSB-1:0] = usbMask;
        end else if (wb_adr_i == `ADR_CTL) begin
            rdData[2:0] = ctl;
        end else if (wb_adr_i == `ADR_EPSTAT) begin
            rdData[15:0] = pend[15:0];
        end else if (wb_adr_i == `ADR_EPMASK) begin
            rdData[15:0] = epMask;
        end else if (wb_adr_i == `ADR_MISC) begin
            rdData[`NMISC-1:0] = pend[`SRC_MISC +: `NMISC];
        end else if (wb_adr_i == `ADR_POWER) begin
            rdData[`PWR_IDLE] = idleBit;
            rdData[`PWR_SUSP] = linkState != irq_agg_pkg::LINK_ACTIVE;
        end else if (wb_adr_i == `ADR_WAKEMASK) begin
            rdData[7:0] = wakeMask;
        end
    end

    // single-wait classic slave, unmapped reads return zero
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
            wb_dat_o <= rdData;
        end
    end

    // idle, frame and global reset counters
    always_comb begin
        next_idleCnt = '0;
        if (usbEvt.busIdleJ && (linkState == irq_agg_pkg::LINK_ACTIVE)
            && (idleCnt <= 17'(SUSPEND_CYCLES))) begin
            next_idleCnt = idleCnt + 17'h1;
        end else if (usbEvt.busIdleJ) begin
            next_idleCnt = idleCnt;
        end
        next_frameCnt = '0;
        if (!usbEvt.sofRx && !missHit && (linkState == irq_agg_pkg::LINK_ACTIVE)) begin
            next_frameCnt = frameCnt + 16'h1;
        end
        next_gresCnt = (gresCnt != 4'h0) ? gresCnt - 4'h1 : 4'h0;
        if (gres) begin
            next_gresCnt = `GRES_CYCLES;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            idleCnt <= '0;
            frameCnt <= '0;
            gresCnt <= '0;
        end else begin
            idleCnt <= next_idleCnt;
            frameCnt <= next_frameCnt;
            gresCnt <= next_gresCnt;
        end
    end

    // suspend and clock-stop sequencing
    always_comb begin
        next_linkState = linkState;
        case (linkState)
            irq_agg_pkg::LINK_ACTIVE: begin
                if (suspendHit) begin
                    next_linkState = irq_agg_pkg::LINK_SUSPENDED;
                end
            end
            irq_agg_pkg::LINK_SUSPENDED: begin
                if (wake) begin
                    next_linkState = irq_agg_pkg::LINK_ACTIVE;
                end else if (idleBit) begin
                    // idle request stops the core clock
                    next_linkState = irq_agg_pkg::LINK_CLK_STOPPED;
                end
            end
            default: begin
                if (wake) begin
                    next_linkState = irq_agg_pkg::LINK_ACTIVE;
                end
            end
        endcase
        if (gres) begin
            next_linkState = irq_agg_pkg::LINK_ACTIVE;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            linkState <= irq_agg_pkg::LINK_ACTIVE;
        end else begin
            linkState <= next_linkState;
        end
    end

    // endpoint and usb masks gate the merge
    assign enVec = {4'hf, usbMask, epMask};
    // OR of every enabled pending source
    assign anyEn = |(pend & enVec);

    // registered outputs toward the core and pins
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mergedIrqInput <= 1'b0;
            secondaryIrqInput <= 1'b1;
            cpuClkRun <= 1'b1;
            cpuReset <= 1'b0;
            resetOutPin <= 1'b0;
            usbLogicReset <= 1'b0;
        end else begin
            mergedIrqInput <= anyEn;
            // pin as interrupt, else held inactive
            secondaryIrqInput <= ctl[`CTL_P33IRQ] ? syncIn[1 + `P3_IRQ_BIT] : 1'b1;
            cpuClkRun <= next_linkState != irq_agg_pkg::LINK_CLK_STOPPED;
            cpuReset <= next_gresCnt != 4'h0;
            resetOutPin <= next_gresCnt != 4'h0;
            // usb logic reset on bus reset
            usbLogicReset <= usbEvt.busReset;
        end
    end

    property p_merge;
        @(posedge clk_sys) disable iff (rst) anyEn |=> mergedIrqInput;
    endproperty
    a_merge: assert property (p_merge) else $error("merged interrupt missing");
    property p_out_iso;
        @(posedge clk_sys) disable iff (rst)
            !pend[`SRC_OUT] && usbEvt.outIso[0] |=> !pend[`SRC_OUT];
    endproperty
    a_out_iso: assert property (p_out_iso) else $error("iso OUT raised interrupt");
    property p_in_ack;
        @(posedge clk_sys) disable iff (rst)
            usbEvt.inAck[0] && !usbEvt.inIso[0] |=> pend[`SRC_IN];
    endproperty
    a_in_ack: assert property (p_in_ack) else $error("IN interrupt not raised");
    property p_hold;
        @(posedge clk_sys) disable iff (rst)
            pend[`SRC_OUT] && !clrVec[`SRC_OUT] |=> pend[`SRC_OUT];
    endproperty
    a_hold: assert property (p_hold) else $error("pending dropped without clear");
    property p_gres;
        @(posedge clk_sys) disable iff (rst)
            gres |=> (cpuReset && resetOutPin && !pend[`SRC_RST])[*8];
    endproperty
    a_gres: assert property (p_gres) else $error("global reset pulse wrong");
    property p_fnreset;
        @(posedge clk_sys) disable iff (rst)
            usbEvt.busReset && !ctl[`CTL_FRGE] |=> pend[`SRC_RST] && usbLogicReset;
    endproperty
    a_fnreset: assert property (p_fnreset) else $error("function reset not flagged");
    property p_suspend;
        @(posedge clk_sys) disable iff (rst)
            suspendHit && !gres |=> pend[`SRC_SUS] && linkState != irq_agg_pkg::LINK_ACTIVE;
    endproperty
    a_suspend: assert property (p_suspend) else $error("suspend not entered");
    property p_missing;
        @(posedge clk_sys) disable iff (rst)
            missHit && !gres |=> pend[`SRC_MISS] && frameCnt == 16'h0;
    endproperty
    a_missing: assert property (p_missing) else $error("missing frame not flagged");
    property p_overrun;
        @(posedge clk_sys) disable iff (rst)
            usbEvt.setupOk && pend[`SRC_SETUP] && !gres |=> pend[`SRC_OVR] && pend[`SRC_SETUP];
    endproperty
    a_overrun: assert property (p_overrun) else $error("setup overrun not flagged");
    property p_clkstop;
        @(posedge clk_sys) disable iff (rst)
            linkState == irq_agg_pkg::LINK_CLK_STOPPED |-> !cpuClkRun;
    endproperty
    a_clkstop: assert property (p_clkstop) else $error("core clock runs in stop");
    property p_ext;
        @(posedge clk_sys) disable iff (rst) extFall && ctl[`CTL_XEN] |=> pend[`SRC_EXT];
    endproperty
    a_ext: assert property (p_ext) else $error("external edge lost");
endmodule

// >>> dv/core_model.sv
// wishbone master model of the controller core
`timescale 1ns/10ps
module core_model (
    input wire logic clk_sys,
    input wire logic wbAck,
    input wire logic [31:0] wbDatIn,
    output logic wbCyc,
    output logic wbStb,
    output logic wbWe,
    output logic [7:0] wbAdr,
    output logic [3:0] wbSel,
    output logic [31:0] wbDatOut
);
    // bus idle at time zero
    initial begin
        wbCyc = 1'b0;
        wbStb = 1'b0;
        wbWe = 1'b0;
        wbAdr = 8'h00;
        wbSel = 4'hf;
        wbDatOut = 32'h00000000;
    end

    // one classic cycle held until ack is sampled, then released with scrambled lines
    task automatic access(input logic we, input logic [7:0] adr, input logic [31:0] wdat,
                          output logic [31:0] rdat);
        @(posedge clk_sys);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbSel <= 4'hf;
        wbAdr <= adr;
        wbDatOut <= wdat;
        @(posedge clk_sys);
        while (wbAck !== 1'b1) begin
            @(posedge clk_sys);
        end
        rdat = wbDatIn;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
        wbAdr <= ~adr;
        wbDatOut <= ~wdat;
    endtask

    task automatic wbWrite(input logic [7:0] adr, input logic [31:0] wdat);
        logic [31:0] unused;
        access(1'b1, adr, wdat, unused);
    endtask

    task automatic wbRead(input logic [7:0] adr, output logic [31:0] rdat);
        access(1'b0, adr, 32'h00000000, rdat);
    endtask

    task automatic clearSrc(input logic [4:0] idx);
        wbWrite(8'h18, {27'h0000000, idx});
    endtask
endmodule

// >>> dv/usb_streaming_irq_aggregator_test.sv
// self-checking bench for the interrupt aggregator
`timescale 1ns/10ps
module usb_streaming_irq_aggregator_test;
    logic clk_sys, rst, wbCyc, wbStb, wbWe, wbAck;
    logic [7:0] wbAdr;
    logic [3:0] wbSel;
    logic [31:0] wbDatW, wbDatR;
    irq_agg_pkg::usb_evt_t evt, evtIn;
    logic idleJ, serialIrq, dma0Done, dma1Done, externalIrqN;
    logic [7:0] port3Pin;
    logic mergedIrqInput, secondaryIrqInput, cpuClkRun, cpuReset, resetOutPin, usbLogicReset;
    int error_cnt = 0;
    int check_count = 0;

    usb_streaming_irq_aggregator #(.SUSPEND_CYCLES(20), .FRAME_CYCLES(16))
    u_usb_streaming_irq_aggregator (
        .clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
        .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW), .wb_ack_o(wbAck),
        .wb_dat_o(wbDatR), .usbEvt(evtIn), .serialIrq(serialIrq), .dma0Done(dma0Done),
        .dma1Done(dma1Done), .externalIrqN(externalIrqN), .port3Pin(port3Pin),
        .mergedIrqInput(mergedIrqInput), .secondaryIrqInput(secondaryIrqInput),
        .cpuClkRun(cpuClkRun), .cpuReset(cpuReset), .resetOutPin(resetOutPin),
        .usbLogicReset(usbLogicReset)
    );

    core_model u_core_model (
        .clk_sys(clk_sys), .wbAck(wbAck), .wbDatIn(wbDatR), .wbCyc(wbCyc), .wbStb(wbStb),
        .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatOut(wbDatW)
    );

    // idle-J level merged into the pulse struct
    always_comb begin
        evtIn = evt;
        evtIn.busIdleJ = idleJ;
    end

    // 20 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_core_model.wbWrite(a, d);
    endtask

    task automatic clr(input logic [4:0] idx);
        u_core_model.clearSrc(idx);
    endtask

    // end every one-cycle strobe
    task automatic fire();
        tick(1);
        evt <= '0;
        serialIrq <= 1'b0;
        dma0Done <= 1'b0;
        dma1Done <= 1'b0;
    endtask

    task automatic chkBit(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: pin %b expected %b", $time, got, exp);
        end
    endtask

    task automatic chkReg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        logic [31:0] d;
        u_core_model.wbRead(a, d);
        check_count++;
        if ((d & m) !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: reg %h read %h expected %h", $time, a, d & m, exp);
        end
    endtask

    task automatic tReset();
        chkBit(mergedIrqInput, 1'b0); // idle merged pin
        chkBit(secondaryIrqInput, 1'b1); // idle secondary pin
        chkBit(cpuClkRun, 1'b1); // clock running
        wr(8'h40, 32'hffffffff);
        chkReg(8'h40, 32'hffffffff, 32'h0); // unmapped reads zero
        chkReg(8'h10, 32'hffffffff, 32'h0); // endpoint mask clear
    endtask

    task automatic tEndpoints();
        wr(8'h10, 32'h0000ffff);
        evt.outDone <= 8'h29;
        evt.outIso <= 8'h21;
        evt.inAck <= 8'hc1;
        evt.inIso <= 8'h40;
        fire();
        tick(3);
        chkReg(8'h0c, 32'hffff, 32'h0881); // iso suppressed
        chkBit(mergedIrqInput, 1'b1); // merged pin
        clr(5'd11);
        chkReg(8'h0c, 32'hffff, 32'h0081); // one cleared
        clr(5'd7);
        clr(5'd0);
        tick(3);
        chkBit(mergedIrqInput, 1'b0); // all cleared
        wr(8'h10, 32'h0);
        evt.outDone <= 8'h01;
        fire();
        tick(3);
        chkBit(mergedIrqInput, 1'b0); // masked source
        chkReg(8'h0c, 32'hffff, 32'h0100); // status kept
        clr(5'd8);
    endtask

    task automatic tUsb();
        wr(8'h04, 32'h6f);
        evt.sofRx <= 1'b1;
        evt.setupOk <= 1'b1;
        fire();
        tick(2);
        evt.setupOk <= 1'b1;
        fire();
        tick(20);
        chkReg(8'h00, 32'h68, 32'h68); // frame and setup flags
        chkReg(8'h00, 32'h10, 32'h10); // missing frame
        clr(5'd19);
        clr(5'd20);
        clr(5'd21);
        clr(5'd22);
        chkReg(8'h00, 32'h6f, 32'h0); // usb flags cleared
    endtask

    task automatic tBusReset();
        logic seen;
        seen = 1'b0;
        evt.busReset <= 1'b1;
        fire();
        repeat (4) begin
            tick(1);
            seen = seen | usbLogicReset;
            chkBit(cpuReset, 1'b0); // no core reset
        end
        chkBit(seen, 1'b1); // usb logic reset
        chkReg(8'h00, 32'h01, 32'h01); // flag kept
        chkBit(mergedIrqInput, 1'b1); // function reset interrupt
        clr(5'd16);
        tick(3);
        chkBit(mergedIrqInput, 1'b0); // cleared by vector
        wr(8'h08, 32'h1);
        seen = 1'b0;
        evt.busReset <= 1'b1;
        fire();
        repeat (14) begin
            tick(1);
            seen = seen | (cpuReset & resetOutPin);
        end
        chkBit(seen, 1'b1); // core and pin reset
        chkReg(8'h00, 32'h01, 32'h0); // status cleared
        wr(8'h08, 32'h0);
    endtask

    task automatic tSuspend();
        idleJ <= 1'b1;
        tick(25);
        chkReg(8'h00, 32'h02, 32'h02); // suspend flag
        chkReg(8'h1c, 32'h02, 32'h02); // suspended state
        wr(8'h1c, 32'h1);
        tick(2);
        chkBit(cpuClkRun, 1'b0); // clock stopped
        idleJ <= 1'b0;
        evt.busActivity <= 1'b1;
        fire();
        tick(3);
        chkBit(cpuClkRun, 1'b1); // clock restarted
        chkReg(8'h00, 32'h04, 32'h04); // resume flag
        clr(5'd17);
        clr(5'd18);
    endtask

    task automatic tWake();
        idleJ <= 1'b1;
        tick(25);
        idleJ <= 1'b0;
        wr(8'h20, 32'h04);
        wr(8'h1c, 32'h1);
        tick(2);
        port3Pin <= 8'hfb;
        tick(6);
        chkBit(cpuClkRun, 1'b0); // masked pin ignored
        port3Pin <= 8'hfa;
        tick(6);
        chkBit(cpuClkRun, 1'b1); // pin wakes
        chkReg(8'h00, 32'h04, 32'h0); // no resume flag
        port3Pin <= 8'hff;
        clr(5'd17);
    endtask

    task automatic tExternal();
        wr(8'h08, 32'h4);
        serialIrq <= 1'b1;
        dma0Done <= 1'b1;
        dma1Done <= 1'b1;
        externalIrqN <= 1'b0;
        fire();
        tick(5);
        chkReg(8'h14, 32'hf, 32'hf); // serial dma external
        chkBit(mergedIrqInput, 1'b1); // misc merged
        clr(5'd23);
        clr(5'd24);
        clr(5'd25);
        clr(5'd26);
        tick(6);
        chkReg(8'h14, 32'hf, 32'h0); // held low once only
        externalIrqN <= 1'b1;
        tick(4);
        externalIrqN <= 1'b0;
        tick(6);
        chkReg(8'h14, 32'h8, 32'h8); // new fall seen
        clr(5'd26);
        externalIrqN <= 1'b1;
    endtask

    task automatic tSecondary();
        wr(8'h08, 32'h2);
        port3Pin <= 8'hf7;
        tick(4);
        chkBit(secondaryIrqInput, 1'b0); // pin routed
        wr(8'h08, 32'h0);
        tick(3);
        chkBit(secondaryIrqInput, 1'b1); // gpio use
        port3Pin <= 8'hff;
    endtask

    task automatic wrap_up();
        if (error_cnt == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // reset, then every scenario in turn
    initial begin
        rst = 1'b1;
        evt = '0;
        idleJ = 1'b0;
        serialIrq = 1'b0;
        dma0Done = 1'b0;
        dma1Done = 1'b0;
        externalIrqN = 1'b1;
        port3Pin = 8'hff;
        tick(20);
        rst <= 1'b0;
        tick(1);
        tReset();
        tEndpoints();
        tUsb();
        tBusReset();
        tSuspend();
        tWake();
        tExternal();
        tSecondary();
        wrap_up();
    end

    // watchdog against a hung handshake
    initial begin
        tick(6000);
        error_cnt++;
        wrap_up();
    end
endmodule
